// ===== logic/vic_ctrl.sv
// vic_ctrl: control and status of a vectored interrupt controller, axi4-lite slave.
// assumes source requests come from logic on clk; external inputs are pins.
`timescale 1ns/1ps

module vic_ctrl
  import vic_pkg::*;
#(
  parameter int NUM_SRC = VIC_NUM_SRC
)
(
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic [NUM_SRC-1:0] src_req,
  input  wire logic [4:0]         ext_pin,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic                    cpu_irq,
  output logic [5:0]              cpu_vector,
  output logic [2:0]              cpu_level,
  output logic                    cpu_shadow,
  output logic                    irq
);

  localparam int NSRC = NUM_SRC + VIC_NUM_EXT;

  initial begin
    if (NUM_SRC < 1 || NUM_SRC > 8) $error("NUM_SRC must be 1..8");
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  vic_ctrl_t       ctrl_q;
  logic [31:0]     reload_q;
  logic [12:0]     flags_q, flags_d;
  logic [12:0]     enable_q;
  logic [63:0]     prio_q;
  vic_req_t        pres_q;
  logic [VIC_NUM_EV-1:0] ev_st_q, ev_msk_q;
  logic [4:0]      ext_s1_q, ext_s2_q, ext_s3_q;
  logic            awpend_q, wpend_q, bvalid_q, rvalid_q;
  logic [7:0]      awaddr_q;
  logic [31:0]     wdata_q, rdata_q;
  logic [1:0]      bresp_q, rresp_q;
  logic            cpu_irq_q, irq_q;

  // ----------------------------------------------------------------------
  // external pin edge detect
  // ----------------------------------------------------------------------
  wire [4:0] rise_ev = ext_s2_q & ~ext_s3_q;
  wire [4:0] fall_ev = ~ext_s2_q & ext_s3_q;
  wire [4:0] ext_ev  = (rise_ev & ctrl_q.edge_pol) | (fall_ev & ~ctrl_q.edge_pol);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_q <= 5'h0;
      ext_s2_q <= 5'h0;
      ext_s3_q <= 5'h0;
    end else begin
      ext_s1_q <= ext_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // ----------------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------------
  // the last external source's priority runs past bit 63; the missing bit reads zero
  function automatic logic [2:0] src_prio(input logic [63:0] p, input int i);
    logic [64:0] w;
    w = {1'b0, p};
    return w[i*5+2 +: 3];
  endfunction

  function automatic logic [1:0] src_sub(input logic [63:0] p, input int i);
    return p[i*5 +: 2];
  endfunction

  logic [12:0]   events;
  logic [12:0]   pend;
  vic_req_t      best;
  logic          tmr_busy, tmr_expire;
  wire           present;

  assign events = {ext_ev, {(8-NUM_SRC){1'b0}}, src_req} & {5'h1f, {(8-NUM_SRC){1'b0}}, {NUM_SRC{1'b1}}};

  always_comb begin
    pend = flags_q & enable_q;
    best = '0;
    for (int i = 0; i < 13; i++) begin
      // held-back levels wait while the proximity timer runs
      if (pend[i] && src_prio(prio_q, i) != 3'h0 &&
          !(tmr_busy && src_prio(prio_q, i) <= ctrl_q.thr)) begin
        if (!best.valid || src_prio(prio_q, i) > best.level ||
            (src_prio(prio_q, i) == best.level && src_sub(prio_q, i) > best.sub)) begin
          best.valid = 1'b1;
          best.level = src_prio(prio_q, i);
          best.sub   = src_sub(prio_q, i);
          best.vec   = ctrl_q.multi_handler_mode ? 6'(i) : 6'h0;
        end
      end
    end
  end

  assign present = best.valid && (!cpu_irq_q || best.vec != pres_q.vec || best.level != pres_q.level);

  vic_prox_timer u_timer (
    .clk        (clk),
    .rst_b      (rst_b),
    .thr        (ctrl_q.thr),
    .trig       (present),
    .trig_level (best.level),
    .reload     (reload_q),
    .busy       (tmr_busy),
    .expire     (tmr_expire)
  );

  // ----------------------------------------------------------------------
  // axi4-lite decode
  // ----------------------------------------------------------------------
  wire do_write = awpend_q && wpend_q && !bvalid_q;
  wire do_read  = s_axi_arvalid && !rvalid_q;
  wire wr_ctrl  = do_write && awaddr_q == VIC_OFS_CONTROL;
  wire wr_stat  = do_write && awaddr_q == VIC_OFS_STATUS;
  wire wr_rel   = do_write && awaddr_q == VIC_OFS_RELOAD;
  wire wr_flag  = do_write && awaddr_q == VIC_OFS_FLAGS;
  wire wr_en    = do_write && awaddr_q == VIC_OFS_ENABLE;
  wire wr_plo   = do_write && awaddr_q == VIC_OFS_PRIO_LO;
  wire wr_phi   = do_write && awaddr_q == VIC_OFS_PRIO_HI;
  wire wr_ist   = do_write && awaddr_q == VIC_OFS_IRQ_ST;
  wire wr_imsk  = do_write && awaddr_q == VIC_OFS_IRQ_MSK;
  wire wr_hit   = wr_ctrl | wr_stat | wr_rel | wr_flag | wr_en | wr_plo | wr_phi | wr_ist | wr_imsk;
  logic [3:0] s_axi_wstrb_q;
  wire [31:0] wmask = {{8{s_axi_wstrb_q[3]}}, {8{s_axi_wstrb_q[2]}}, {8{s_axi_wstrb_q[1]}}, {8{s_axi_wstrb_q[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    return (old & ~m) | (nw & m);
  endfunction

  wire [31:0] ctrl_word = {15'h0, ctrl_q.shadow, 3'h0, ctrl_q.multi_handler_mode, 1'b0, ctrl_q.thr, 3'h0, ctrl_q.edge_pol};
  wire [31:0] stat_word = {21'h0, pres_q.level, 2'h0, pres_q.vec};
  wire [31:0] ctrl_new  = merge(ctrl_word, wdata_q, wmask);
  wire [31:0] stat_new  = merge(stat_word, wdata_q, wmask);
  wire [31:0] en_new    = merge({19'h0, enable_q}, wdata_q, wmask);

  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      VIC_OFS_CONTROL: rd_word = ctrl_word;
      VIC_OFS_STATUS:  rd_word = stat_word;
      VIC_OFS_RELOAD:  rd_word = reload_q;
      VIC_OFS_FLAGS:   rd_word = {19'h0, flags_q};
      VIC_OFS_ENABLE:  rd_word = {19'h0, enable_q};
      VIC_OFS_PRIO_LO: rd_word = prio_q[31:0];
      VIC_OFS_PRIO_HI: rd_word = prio_q[63:32];
      VIC_OFS_IRQ_ST:  rd_word = {30'h0, ev_st_q};
      VIC_OFS_IRQ_MSK: rd_word = {30'h0, ev_msk_q};
      default: begin
        rd_word = 32'h0;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // hardware set wins over a software clear in the same cycle
  assign flags_d = (wr_flag ? (flags_q & ~wdata_q[12:0]) : flags_q) | events;
  wire [1:0] ev_set = {tmr_expire, present};

  // ----------------------------------------------------------------------
  // bus channel state
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awpend_q <= 1'b0;
      wpend_q  <= 1'b0;
      awaddr_q <= 8'h0;
      wdata_q  <= 32'h0;
      s_axi_wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= VIC_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= VIC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awpend_q) begin
        awpend_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wpend_q) begin
        wpend_q       <= 1'b1;
        wdata_q       <= s_axi_wdata;
        s_axi_wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        awpend_q <= 1'b0;
        wpend_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? VIC_RESP_OKAY : VIC_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (do_read) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_word;
        rresp_q  <= rd_hit ? VIC_RESP_OKAY : VIC_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q   <= '0;
      reload_q <= VIC_RESET_VAL;
      flags_q  <= 13'h0;
      enable_q <= 13'h0;
      prio_q   <= 64'h0;
      ev_st_q  <= '0;
      ev_msk_q <= '0;
    end else begin
      flags_q <= flags_d;
      ev_st_q <= (wr_ist ? (ev_st_q & ~wdata_q[1:0]) : ev_st_q) | ev_set;
      if (wr_ctrl) begin
        ctrl_q.shadow   <= ctrl_new[VIC_POS_SHADOW];
        ctrl_q.multi_handler_mode     <= ctrl_new[VIC_POS_MULTI_HANDLER_MODE];
        ctrl_q.thr      <= ctrl_new[VIC_POS_THR +: 3];
        ctrl_q.edge_pol <= ctrl_new[VIC_POS_EDGE +: 5];
      end
      if (wr_rel) reload_q <= merge(reload_q, wdata_q, wmask);
      if (wr_en) enable_q <= en_new[12:0];
      if (wr_plo) prio_q[31:0] <= merge(prio_q[31:0], wdata_q, wmask);
      if (wr_phi) prio_q[63:32] <= merge(prio_q[63:32], wdata_q, wmask);
      if (wr_imsk) ev_msk_q <= wdata_q[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // presentation to the core
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pres_q     <= '0;
      cpu_irq_q  <= 1'b0;
      cpu_shadow <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      cpu_irq_q <= best.valid;
      irq_q     <= |(ev_st_q & ev_msk_q);
      if (present) begin
        pres_q     <= best;
        cpu_shadow <= !ctrl_q.multi_handler_mode && ctrl_q.shadow;
      end else if (wr_stat) begin
        pres_q.level <= stat_new[VIC_POS_LEVEL +: 3];
        pres_q.vec   <= stat_new[VIC_POS_VEC +: 6];
      end
    end
  end

  assign s_axi_awready = !awpend_q;
  assign s_axi_wready  = !wpend_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign cpu_irq       = cpu_irq_q;
  assign cpu_vector    = pres_q.vec;
  assign cpu_level     = pres_q.level;
  assign irq           = irq_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  shadow_use_a: assert property (@(posedge clk) disable iff (!rst_b)
    (present && !ctrl_q.shadow) |=> !cpu_shadow) else $error("shadow set used while off");
  single_vec_a: assert property (@(posedge clk) disable iff (!rst_b)
    (present && !ctrl_q.multi_handler_mode) |=> cpu_vector == 6'h0) else $error("vector nonzero in single mode");
  edge_pick_a: assert property (@(posedge clk) disable iff (!rst_b)
    (rise_ev[0] && !ctrl_q.edge_pol[0]) |-> !ext_ev[0]) else $error("rising edge taken while falling");
  level_shown_a: assert property (@(posedge clk) disable iff (!rst_b)
    present |=> stat_word[10:8] == $past(best.level)) else $error("level not shown");
  vector_shown_a: assert property (@(posedge clk) disable iff (!rst_b)
    present |=> stat_word[5:0] == $past(best.vec)) else $error("vector not shown");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl_word[31:17] == 15'h0 && ctrl_word[15:13] == 3'h0 && stat_word[31:11] == 21'h0)
    else $error("reserved bits nonzero");
  flag_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    events[0] |=> flags_q[0]) else $error("flag lost");
  hold_back_a: assert property (@(posedge clk) disable iff (!rst_b)
    (tmr_busy && best.valid) |-> best.level > ctrl_q.thr) else $error("held level presented");
  cover_multi_c: cover property (@(posedge clk) disable iff (!rst_b) present && ctrl_q.multi_handler_mode);
  cover_ext_c: cover property (@(posedge clk) disable iff (!rst_b) |ext_ev);
  cover_irq_c: cover property (@(posedge clk) disable iff (!rst_b) irq_q);

endmodule

// ===== logic/vic_pkg.sv
// vic_pkg: register map, field positions and shared types of the interrupt controller.
// assumes a 32-bit axi4-lite register bus; every register is one aligned word.
package vic_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] VIC_OFS_CONTROL = 8'h00;
  localparam logic [7:0] VIC_OFS_STATUS  = 8'h04;
  localparam logic [7:0] VIC_OFS_RELOAD  = 8'h08;
  localparam logic [7:0] VIC_OFS_FLAGS   = 8'h0c;
  localparam logic [7:0] VIC_OFS_ENABLE  = 8'h10;
  localparam logic [7:0] VIC_OFS_PRIO_LO = 8'h14;
  localparam logic [7:0] VIC_OFS_PRIO_HI = 8'h18;
  localparam logic [7:0] VIC_OFS_IRQ_ST  = 8'h1c;
  localparam logic [7:0] VIC_OFS_IRQ_MSK = 8'h20;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int VIC_POS_SHADOW = 16;
  localparam int VIC_POS_MULTI_HANDLER_MODE   = 12;
  localparam int VIC_POS_THR    = 8;
  localparam int VIC_POS_EDGE   = 0;
  localparam int VIC_POS_LEVEL  = 8;
  localparam int VIC_POS_VEC    = 0;
  localparam int VIC_NUM_EXT    = 5;
  localparam int VIC_NUM_SRC    = 8;
  localparam logic [31:0] VIC_RESET_VAL = 32'h0000_0000;

  // axi responses
  localparam logic [1:0] VIC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] VIC_RESP_SLVERR = 2'h2;

  // interrupt status bits of the controller itself
  localparam int VIC_EV_PRESENT = 0;
  localparam int VIC_EV_EXPIRE  = 1;
  localparam int VIC_NUM_EV     = 2;

  typedef struct packed {
    logic       shadow;
    logic       multi_handler_mode;
    logic [2:0] thr;
    logic [4:0] edge_pol;
  } vic_ctrl_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] level;
    logic [1:0] sub;
    logic [5:0] vec;
  } vic_req_t;

endpackage

// ===== logic/vic_prox_timer.sv
// vic_prox_timer: temporal proximity down-counter.
// assumes trigger and threshold come from logic on the same clock.
`timescale 1ns/1ps
module vic_prox_timer
  import vic_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [2:0]  thr,
  input  wire logic        trig,
  input  wire logic [2:0]  trig_level,
  input  wire logic [31:0] reload,
  output logic             busy,
  output logic             expire
);

  logic [31:0] cnt_q;
  logic        busy_q;
  logic        expire_q;
  wire         starts;

  // ----------------------------------------------------------------------
  // start decode
  // ----------------------------------------------------------------------
  assign starts = trig && (thr != 3'h0) && (trig_level <= thr) && !busy_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q    <= 32'h0;
      busy_q   <= 1'b0;
      expire_q <= 1'b0;
    end else begin
      expire_q <= 1'b0;
      if (starts) begin
        cnt_q  <= reload;
        busy_q <= (reload != 32'h0);
      end else if (busy_q) begin
        cnt_q <= cnt_q - 32'h1;
        if (cnt_q == 32'h1) begin
          busy_q   <= 1'b0;
          expire_q <= 1'b1;
        end
      end
    end
  end

  assign busy   = busy_q;
  assign expire = expire_q;

  disabled_thr_a: assert property (@(posedge clk) disable iff (!rst_b)
    (thr == 3'h0) |-> !starts) else $error("timer started while disabled");
  load_value_a: assert property (@(posedge clk) disable iff (!rst_b)
    starts |=> (cnt_q == $past(reload))) else $error("timer did not load reload");
  count_down_a: assert property (@(posedge clk) disable iff (!rst_b)
    (busy_q && !starts && cnt_q > 32'h1) |=> busy_q && cnt_q == $past(cnt_q) - 32'h1)
    else $error("timer did not count down");
  level_one_a: assert property (@(posedge clk) disable iff (!rst_b)
    (thr == 3'h1 && trig_level > 3'h1) |-> !starts) else $error("level above 1 started timer");
  cover_start_c: cover property (@(posedge clk) disable iff (!rst_b) starts);
  cover_expire_c: cover property (@(posedge clk) disable iff (!rst_b) expire_q);

endmodule

// ===== tb/vic_core_model.sv
// vic_core_model: processor side that takes the vector, level and shadow choice presented at each rise of cpu_irq.
// assumes the cpu_* outputs of vic_ctrl on the same clock.
`timescale 1ns/1ps
module vic_core_model
  import vic_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       cpu_irq,
  input  wire logic [5:0] cpu_vector,
  input  wire logic [2:0] cpu_level,
  input  wire logic       cpu_shadow,
  output logic [5:0]      taken_vector,
  output logic [2:0]      taken_level,
  output logic            taken_shadow,
  output int              taken_count
);
  logic irq_q;

  // ----------------------------------------------------------------------
  // take a request when cpu_irq rises
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q        <= 1'b0;
      taken_vector <= 6'h00;
      taken_level  <= 3'h0;
      taken_shadow <= 1'b0;
      taken_count  <= 0;
    end else begin
      irq_q <= cpu_irq;
      if (cpu_irq && !irq_q) begin
        // vector and level are taken as reported in both single and multi mode
        taken_vector <= cpu_vector;
        taken_level  <= cpu_level;
        taken_shadow <= cpu_shadow;
        taken_count  <= taken_count + 1;
      end
    end
  end
endmodule

// ===== tb/vic_ctrl_test.sv
// vic_ctrl_test: self-checking bench of the interrupt controller's control and status block.
// assumes vic_ctrl with its default source count and the core model beside it.
`timescale 1ns/1ps
module vic_ctrl_test
  import vic_pkg::*;
;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
    logic [1:0]  resp;
  } vic_row_t;

  logic        clk = 1'b0;
  logic        rst_b;
  logic [7:0]  src_req, s_axi_awaddr, s_axi_araddr;
  logic [4:0]  ext_pin;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        cpu_irq, cpu_shadow, irq, taken_shadow, hold;
  logic [5:0]  cpu_vector, taken_vector;
  logic [2:0]  cpu_level, taken_level, thr, lvl;
  int          taken_count, n, num_errors, check_count;
  vic_row_t    rows [5];
  logic [6:0]  pcase [6];

  always #2.5 clk = ~clk;

  vic_ctrl u_vic_ctrl (.clk(clk), .rst_b(rst_b), .src_req(src_req), .ext_pin(ext_pin),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cpu_irq(cpu_irq),
    .cpu_vector(cpu_vector), .cpu_level(cpu_level), .cpu_shadow(cpu_shadow), .irq(irq));

  vic_core_model u_vic_core_model (.clk(clk), .rst_b(rst_b), .cpu_irq(cpu_irq),
    .cpu_vector(cpu_vector), .cpu_level(cpu_level), .cpu_shadow(cpu_shadow),
    .taken_vector(taken_vector), .taken_level(taken_level), .taken_shadow(taken_shadow),
    .taken_count(taken_count));

  // ----------------------------------------------------------------------
  // comparison, bus cycles and stimulus helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= v;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic wo(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] resp;
    wr(a, v, resp);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    src_req <= m;
    @(posedge clk);
    src_req <= 8'h00;
  endtask

  // counts cycles until the given vector is requested, giving up after 200
  task automatic wait_vec(input logic [5:0] v, output int cnt);
    cnt = 0;
    while (!(cpu_irq === 1'b1 && cpu_vector === v) && cnt < 200) begin
      @(posedge clk);
      cnt++;
    end
    if (cnt >= 200) num_errors++;
    // let the core model's capture settle before it is read
    @(posedge clk);
  endtask

  task automatic stop_test;
    $display("checks made %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    stop_test;
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {src_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    ext_pin = 5'h15;
    rst_b = 1'b0;
    num_errors = 0;
    check_count = 0;
    rows[0] = '{VIC_OFS_CONTROL, 32'hffff_ffff, 32'h0001_171f, VIC_RESP_OKAY};
    rows[1] = '{VIC_OFS_STATUS, 32'hffff_ffff, 32'h0000_073f, VIC_RESP_OKAY};
    rows[2] = '{VIC_OFS_RELOAD, 32'ha5a5_5a5a, 32'ha5a5_5a5a, VIC_RESP_OKAY};
    rows[3] = '{8'h40, 32'h1234_5678, 32'h0000_0000, VIC_RESP_SLVERR};
    rows[4] = '{VIC_OFS_CONTROL, 32'h0000_0000, 32'h0000_0000, VIC_RESP_OKAY};
    pcase = '{{3'd3, 3'd2, 1'b1}, {3'd3, 3'd4, 1'b0}, {3'd1, 3'd2, 1'b0},
              {3'd1, 3'd1, 1'b1}, {3'd0, 3'd1, 1'b0}, {3'd7, 3'd7, 1'b1}};
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(8'(i * 4), d, r);
      chk(d, VIC_RESET_VAL);
    end
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata, r);
      chk({30'h0, r}, {30'h0, rows[i].resp});
      rd(rows[i].addr, d, r);
      chk({30'h0, r}, {30'h0, rows[i].resp});
      if (rows[i].resp == VIC_RESP_OKAY) chk(d, rows[i].rexp);
    end
    // every pin takes its active edge, then the opposite one
    wo(VIC_OFS_CONTROL, 32'h0000_000a);
    ext_pin <= 5'h0a;
    repeat (6) @(posedge clk);
    rd(VIC_OFS_FLAGS, d, r);
    chk(d & 32'h1f00, 32'h1f00);
    wo(VIC_OFS_FLAGS, 32'h1f00);
    ext_pin <= 5'h15;
    repeat (6) @(posedge clk);
    rd(VIC_OFS_FLAGS, d, r);
    chk(d & 32'h1f00, 32'h0);
    // single mode with shadow set, then the controller's own interrupt
    wo(VIC_OFS_ENABLE, 32'h0000_000c);
    wo(VIC_OFS_PRIO_LO, 32'h000b_d400);
    wo(VIC_OFS_CONTROL, 32'h0001_0000);
    pulse(8'h04);
    wait_vec(6'd0, n);
    chk({26'h0, taken_vector}, 32'h0);
    chk({29'h0, taken_level}, 32'h5);
    chk({31'h0, taken_shadow}, 32'h1);
    rd(VIC_OFS_STATUS, d, r);
    chk(d, 32'h0000_0500);
    chk({31'h0, irq}, 32'h0);
    wo(VIC_OFS_IRQ_MSK, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wo(VIC_OFS_FLAGS, 32'h0000_000c);
    wo(VIC_OFS_IRQ_ST, 32'h3);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // multi mode: subpriority, disabled source, index tie
    wo(VIC_OFS_CONTROL, 32'h0001_1000);
    pulse(8'h0c);
    wait_vec(6'd3, n);
    chk({26'h0, taken_vector}, 32'h3);
    chk({31'h0, taken_shadow}, 32'h0);
    wo(VIC_OFS_FLAGS, 32'h0000_000c);
    wo(VIC_OFS_PRIO_LO, 32'h0000_5400);
    pulse(8'h0c);
    wait_vec(6'd2, n);
    chk({26'h0, taken_vector}, 32'h2);
    wo(VIC_OFS_FLAGS, 32'h0000_000c);
    wo(VIC_OFS_PRIO_LO, 32'h000a_d400);
    pulse(8'h0c);
    wait_vec(6'd2, n);
    chk({26'h0, taken_vector}, 32'h2);
    wo(VIC_OFS_FLAGS, 32'h0000_000c);
    // proximity hold against threshold and level
    wo(VIC_OFS_ENABLE, 32'h0000_0003);
    wo(VIC_OFS_RELOAD, 32'd40);
    foreach (pcase[i]) begin
      {thr, lvl, hold} = pcase[i];
      wo(VIC_OFS_CONTROL, 32'h1000 | (32'(thr) << 8));
      wo(VIC_OFS_PRIO_LO, (32'(lvl) << 2) | (32'(lvl) << 7));
      pulse(8'h01);
      wait_vec(6'd0, n);
      wo(VIC_OFS_FLAGS, 32'h1);
      pulse(8'h02);
      wait_vec(6'd1, n);
      chk(32'(n > 12), 32'(hold));
      chk(32'(n <= 45), 32'h1);
      wo(VIC_OFS_FLAGS, 32'h2);
      repeat (60) @(posedge clk);
    end
    stop_test;
  end
endmodule
